// ### cdsp_pkg.sv
// Purpose: Shared constants and types of the serial command port.
// Assumes: Four-bit register addresses, data sent in whole nibbles.
// Notes:   Reset values of the settings are plain defaults.

package cdsp_pkg;

   // ****************************************************************
   // Register addresses
   // ****************************************************************
   localparam logic [3:0] ADDR_AUTOSEQ  = 4'h4;
   localparam logic [3:0] ADDR_TIMER    = 4'h5;
   localparam logic [3:0] ADDR_KICK     = 4'h6;
   localparam logic [3:0] ADDR_JUMPCNT  = 4'h7;
   localparam logic [3:0] ADDR_OUTMODE  = 4'h8;
   localparam logic [3:0] ADDR_FUNCSEL  = 4'h9;
   localparam logic [3:0] ADDR_AUDIO    = 4'ha;
   localparam logic [3:0] ADDR_SERBUS   = 4'hb;
   localparam logic [3:0] ADDR_SPGAIN   = 4'hc;
   localparam logic [3:0] ADDR_SPCTRL   = 4'hd;
   localparam logic [3:0] ADDR_SPMODE   = 4'he;

   // ****************************************************************
   // Command lengths in bits, address nibble included
   // ****************************************************************
   localparam logic [4:0] LEN_ONE_NIB   = 5'h08;
   localparam logic [4:0] LEN_TWO_NIB   = 5'h0c;
   localparam logic [4:0] LEN_FOUR_NIB  = 5'h14;
   localparam int         SHIFT_W       = 20;

   // ****************************************************************
   // Reset values
   // ****************************************************************
   localparam logic [3:0]  RST_AUTOSEQ  = 4'h0;
   localparam logic [3:0]  RST_TIMER    = 4'h5;
   localparam logic [3:0]  RST_KICK     = 4'h0;
   localparam logic [15:0] RST_JUMPCNT  = 16'h0000;
   localparam logic [3:0]  RST_OUTMODE  = 4'h0;
   localparam logic [7:0]  RST_FUNCSEL  = 8'h00;
   localparam logic [3:0]  RST_AUDIO    = 4'h0;
   localparam logic [3:0]  RST_SERBUS   = 4'h0;
   localparam logic [3:0]  RST_SPGAIN   = 4'h0;
   localparam logic [3:0]  RST_SPCTRL   = 4'h0;
   localparam logic [3:0]  RST_SPMODE   = 4'h0;

   // ****************************************************************
   // Timer bit weights in microseconds, bit 3 first
   // ****************************************************************
   localparam logic [9:0] BLIND_W3 = 10'd180;
   localparam logic [9:0] BLIND_W2 = 10'd90;
   localparam logic [9:0] BLIND_W1 = 10'd50;
   localparam logic [9:0] BLIND_W0 = 10'd20;
   localparam logic [9:0] BRAKE_W3 = 10'd360;
   localparam logic [9:0] BRAKE_W2 = 10'd180;
   localparam logic [9:0] BRAKE_W1 = 10'd90;
   localparam logic [9:0] BRAKE_W0 = 10'd50;

   // Word handed from the shift clock domain to the system clock.
   typedef struct packed {
      logic [4:0]         bit_cnt;
      logic [SHIFT_W-1:0] bits;
   } cdsp_link_word_t;

   // A decoded command.
   typedef struct packed {
      logic [3:0]  addr;
      logic [15:0] data;
      logic [4:0]  len;
   } cdsp_cmd_t;

endpackage : cdsp_pkg

// ### cdsp_cmd_port.sv
// Purpose: Serial command port loading the mode and control settings.
// Assumes: Host shifts on the shift clock and latches with a low pulse.
// Notes:   Settings are write only and leave the block as flop outputs.
//
// How it works
// - Settings change only through the data line, shift clock and strobe, or a reset.
// - While the chip reset pin is low every setting holds its init value.
// - One nibble sets blind time up to 0.34ms and brake time up to 0.68ms.
// - The jump count is 16 bits in four nibbles, most significant first.
// - The shifted command is taken on the falling edge of the strobe.

`timescale 1ns/10ps

module cdsp_cmd_port (
   input  wire logic        clock_i,
   input  wire logic        srst_i,
   input  wire logic        host_shift_clock_i,
   input  wire logic        serial_data_i,
   input  wire logic        host_latch_strobe_i,
   input  wire logic        chip_reset_low_i,
   output logic [3:0]       auto_sequence_command_o,
   output logic [3:0]       sequence_timer_setting_o,
   output logic [8:0]       blind_time_us_o,
   output logic [9:0]       brake_time_us_o,
   output logic [3:0]       kick_time_setting_o,
   output logic [15:0]      track_jump_count_o,
   output logic [3:0]       output_mode_select_o,
   output logic [7:0]       function_select_o,
   output logic [3:0]       audio_control_o,
   output logic [3:0]       serial_bus_control_o,
   output logic [3:0]       spindle_gain_setting_o,
   output logic [3:0]       spindle_speed_control_o,
   output logic [3:0]       spindle_speed_mode_o,
   output logic             cmd_update_o,
   output logic             cmd_reject_o
);

   // ****************************************************************
   // Shift clock domain
   // ****************************************************************
   // The shift clock stops between commands, so this side keeps no
   // notion of frames: it shifts and counts bits, and the system side
   // works out each command's length from the count at two strobes.
   // A limitation: the first two shift edges after srst_i still see the
   // reset, so the host sends one throwaway command before real ones.
   logic                    lk_rst_s1_r;
   logic                    lk_rst_s2_r;
   logic [cdsp_pkg::SHIFT_W-1:0] lk_shift_r;
   logic [4:0]              lk_cnt_r;
   cdsp_pkg::cdsp_link_word_t lk_word;

   always_ff @(posedge host_shift_clock_i) begin
      lk_rst_s1_r <= srst_i;
      lk_rst_s2_r <= lk_rst_s1_r;
   end

   always_ff @(posedge host_shift_clock_i) begin
      if (lk_rst_s2_r) begin
         lk_shift_r <= '0;
         lk_cnt_r   <= 5'h00;
      end else begin
         lk_shift_r <= {lk_shift_r[cdsp_pkg::SHIFT_W-2:0],
                        serial_data_i};
         lk_cnt_r   <= lk_cnt_r + 5'h01;
      end
   end

   assign lk_word.bit_cnt = lk_cnt_r;
   assign lk_word.bits    = lk_shift_r;

   // ****************************************************************
   // Pin synchronisers
   // ****************************************************************
   logic lat_s1_r;
   logic lat_s2_r;
   logic lat_d_r;
   logic xr_s1_r;
   logic xr_s2_r;

   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         lat_s1_r <= 1'b1;
         lat_s2_r <= 1'b1;
         lat_d_r  <= 1'b1;
         xr_s1_r  <= 1'b1;
         xr_s2_r  <= 1'b1;
      end else begin
         lat_s1_r <= host_latch_strobe_i;
         lat_s2_r <= lat_s1_r;
         lat_d_r  <= lat_s2_r;
         xr_s1_r  <= chip_reset_low_i;
         xr_s2_r  <= xr_s1_r;
      end
   end

   wire lat_fall = lat_d_r & ~lat_s2_r;
   wire init_now = srst_i | ~xr_s2_r;

   // ****************************************************************
   // Capture and decode
   // ****************************************************************
   // The link word is read only on a synchronised strobe fall. The host
   // has stopped the shift clock well before that edge, so the word has
   // been still for far longer than the two synchroniser stages.
   logic                      cap_v_r;
   cdsp_pkg::cdsp_link_word_t cap_r;
   logic [4:0]                prev_cnt_r;

   always_ff @(posedge clock_i) begin
      if (init_now) begin
         cap_v_r <= 1'b0;
      end else begin
         cap_v_r <= lat_fall;
      end
   end

   // The bit count base follows every strobe, even under the chip reset
   // pin, because the link counter only restarts with srst_i. Clearing
   // it on the pin would make the first command after it look short.
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         cap_r      <= '0;
         prev_cnt_r <= 5'h00;
      end else if (lat_fall) begin
         cap_r      <= lk_word;
         prev_cnt_r <= cap_r.bit_cnt;
      end
   end

   wire [4:0] cmd_len = cap_r.bit_cnt - prev_cnt_r;

   cdsp_pkg::cdsp_cmd_t cmd;
   assign cmd.len  = cmd_len;
   assign cmd.addr = (cmd_len == cdsp_pkg::LEN_FOUR_NIB) ? cap_r.bits[19:16]
                   : (cmd_len == cdsp_pkg::LEN_TWO_NIB)  ? cap_r.bits[11:8]
                   : cap_r.bits[7:4];
   assign cmd.data = (cmd_len == cdsp_pkg::LEN_FOUR_NIB) ? cap_r.bits[15:0]
                   : (cmd_len == cdsp_pkg::LEN_TWO_NIB)
                     ? {8'h00, cap_r.bits[7:0]}
                     : {12'h000, cap_r.bits[3:0]};

   // Each defined address has one legal length; anything else is dropped so a
   // short or broken transfer never corrupts a setting.
   logic [4:0] want_len;
   always_comb begin
      case (cmd.addr)
         cdsp_pkg::ADDR_AUTOSEQ,
         cdsp_pkg::ADDR_TIMER,
         cdsp_pkg::ADDR_KICK,
         cdsp_pkg::ADDR_OUTMODE,
         cdsp_pkg::ADDR_AUDIO,
         cdsp_pkg::ADDR_SERBUS,
         cdsp_pkg::ADDR_SPGAIN,
         cdsp_pkg::ADDR_SPCTRL,
         cdsp_pkg::ADDR_SPMODE: want_len = cdsp_pkg::LEN_ONE_NIB;
         cdsp_pkg::ADDR_FUNCSEL: want_len = cdsp_pkg::LEN_TWO_NIB;
         cdsp_pkg::ADDR_JUMPCNT: want_len = cdsp_pkg::LEN_FOUR_NIB;
         default:               want_len = 5'h00;
      endcase
   end

   wire cmd_ok  = cap_v_r & (want_len != 5'h00) & (cmd.len == want_len);
   wire cmd_bad = cap_v_r & ~cmd_ok;

   function automatic logic sel(input logic [3:0] a);
      sel = cmd_ok & (cmd.addr == a);
   endfunction

   // ****************************************************************
   // Timer weights
   // ****************************************************************
   function automatic logic [9:0] weigh(input logic [3:0] n,
                                        input logic [9:0] w3,
                                        input logic [9:0] w2,
                                        input logic [9:0] w1,
                                        input logic [9:0] w0);
      weigh = (n[3] ? w3 : 10'd0) + (n[2] ? w2 : 10'd0)
            + (n[1] ? w1 : 10'd0) + (n[0] ? w0 : 10'd0);
   endfunction

   wire [3:0] tmr_nxt = sel(cdsp_pkg::ADDR_TIMER) ? cmd.data[3:0]
                      : sequence_timer_setting_o;
   wire [9:0] blind_nxt = weigh(tmr_nxt, cdsp_pkg::BLIND_W3,
                                cdsp_pkg::BLIND_W2, cdsp_pkg::BLIND_W1,
                                cdsp_pkg::BLIND_W0);
   wire [9:0] brake_nxt = weigh(tmr_nxt, cdsp_pkg::BRAKE_W3,
                                cdsp_pkg::BRAKE_W2, cdsp_pkg::BRAKE_W1,
                                cdsp_pkg::BRAKE_W0);

   // ****************************************************************
   // Setting registers
   // ****************************************************************
   always_ff @(posedge clock_i) begin
      if (init_now) begin
         auto_sequence_command_o  <= cdsp_pkg::RST_AUTOSEQ;
         sequence_timer_setting_o <= cdsp_pkg::RST_TIMER;
         kick_time_setting_o      <= cdsp_pkg::RST_KICK;
         track_jump_count_o       <= cdsp_pkg::RST_JUMPCNT;
         output_mode_select_o     <= cdsp_pkg::RST_OUTMODE;
         function_select_o        <= cdsp_pkg::RST_FUNCSEL;
         audio_control_o          <= cdsp_pkg::RST_AUDIO;
         serial_bus_control_o     <= cdsp_pkg::RST_SERBUS;
         spindle_gain_setting_o   <= cdsp_pkg::RST_SPGAIN;
         spindle_speed_control_o  <= cdsp_pkg::RST_SPCTRL;
         spindle_speed_mode_o     <= cdsp_pkg::RST_SPMODE;
      end else begin
         if (sel(cdsp_pkg::ADDR_AUTOSEQ))
            auto_sequence_command_o <= cmd.data[3:0];
         sequence_timer_setting_o <= tmr_nxt;
         if (sel(cdsp_pkg::ADDR_KICK))
            kick_time_setting_o <= cmd.data[3:0];
         if (sel(cdsp_pkg::ADDR_JUMPCNT))
            track_jump_count_o <= cmd.data;
         if (sel(cdsp_pkg::ADDR_OUTMODE))
            output_mode_select_o <= cmd.data[3:0];
         if (sel(cdsp_pkg::ADDR_FUNCSEL))
            function_select_o <= cmd.data[7:0];
         if (sel(cdsp_pkg::ADDR_AUDIO))
            audio_control_o <= cmd.data[3:0];
         if (sel(cdsp_pkg::ADDR_SERBUS))
            serial_bus_control_o <= cmd.data[3:0];
         if (sel(cdsp_pkg::ADDR_SPGAIN))
            spindle_gain_setting_o <= cmd.data[3:0];
         if (sel(cdsp_pkg::ADDR_SPCTRL))
            spindle_speed_control_o <= cmd.data[3:0];
         if (sel(cdsp_pkg::ADDR_SPMODE))
            spindle_speed_mode_o <= cmd.data[3:0];
      end
   end

   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         blind_time_us_o <= 9'h000;
         brake_time_us_o <= 10'h000;
         cmd_update_o    <= 1'b0;
         cmd_reject_o    <= 1'b0;
      end else begin
         blind_time_us_o <= blind_nxt[8:0];
         brake_time_us_o <= brake_nxt;
         cmd_update_o    <= cmd_ok & ~init_now;
         cmd_reject_o    <= cmd_bad & ~init_now;
      end
   end

   // ****************************************************************
   // Checks
   // ****************************************************************
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (srst_i);

   a_init_while_low: assert property (
      $past(~xr_s2_r) |-> (track_jump_count_o == cdsp_pkg::RST_JUMPCNT
                           && sequence_timer_setting_o ==
                              cdsp_pkg::RST_TIMER))
      else $error("Setting left its init value while reset was low.");

   a_no_change_idle: assert property (
      (!$past(cap_v_r) && xr_s2_r && $past(xr_s2_r))
      |-> $stable(track_jump_count_o) && $stable(audio_control_o))
      else $error("Setting changed without a latched command.");

   a_latch_to_update: assert property (
      lat_fall ##1 cmd_ok && !init_now |=> cmd_update_o)
      else $error("Update pulse missing after a good strobe fall.");

   a_jump_count_load: assert property (
      (sel(cdsp_pkg::ADDR_JUMPCNT) && !init_now)
      |=> track_jump_count_o == $past(cap_r.bits[15:0]))
      else $error("Jump count not loaded from four nibbles.");

   a_timer_weights: assert property (
      (sequence_timer_setting_o == 4'h8) [*2]
      |-> blind_time_us_o == 9'd180 && brake_time_us_o == 10'd360)
      else $error("Timer bit 3 weights wrong.");

   a_addr_select: assert property (
      (sel(cdsp_pkg::ADDR_AUDIO) && !init_now)
      |=> audio_control_o == $past(cap_r.bits[3:0])
          && $stable(spindle_speed_mode_o))
      else $error("Address nibble routed data to the wrong setting.");

   a_reject_on_bad: assert property (
      cmd_bad && !init_now |=> cmd_reject_o && !cmd_update_o)
      else $error("Reject pulse missing after a bad command.");

   a_update_one_cycle: assert property (
      cmd_update_o |=> !cmd_update_o)
      else $error("Update pulse lasted more than one cycle.");

   a_len_matches: assert property (
      cmd_update_o |-> $past(cmd.len) == $past(want_len))
      else $error("Setting updated from a command of the wrong length.");

endmodule : cdsp_cmd_port

// ### cdsp_host_model.sv
// Purpose: Behavioural host that shifts commands into the port.
// Assumes: Shift clock 12 ns, strobe moved on falling clock_i edges.
// Notes:   The shift clock stands still low outside frames.
`timescale 1ns/10ps

module cdsp_host_model (
   input  wire logic clock_i,
   output logic      host_shift_clock_o,
   output logic      serial_data_o,
   output logic      host_latch_strobe_o,
   output logic      subcode_pw_read_clock_o,
   output logic      subcode_q_read_clock_o
);
   // ****************************************************************
   // Line levels
   // ****************************************************************
   assign subcode_pw_read_clock_o = 1'b1;
   assign subcode_q_read_clock_o  = 1'b1;

   initial begin
      host_shift_clock_o  = 1'b0;
      serial_data_o       = 1'b0;
      host_latch_strobe_o = 1'b1;
   end

   // Bits go out most significant first, one per shift clock period.
   task automatic shift(input logic [19:0] w, input int n);
      #3;
      for (int i = n - 1; i >= 0; i--) begin
         serial_data_o = w[i];
         #6 host_shift_clock_o = 1'b1;
         #6 host_shift_clock_o = 1'b0;
      end
      // A released data line must not look like a held value.
      serial_data_o = ~serial_data_o;
   endtask : shift

   task automatic send(input logic [3:0] a, input logic [15:0] d,
                       input int n);
      shift(({16'h0, a} << (n - 4)) | {4'h0, d}, n);
      @(negedge clock_i);
      host_latch_strobe_o = 1'b0;
      repeat (4) @(negedge clock_i);
      host_latch_strobe_o = 1'b1;
      repeat (4) @(negedge clock_i);
   endtask : send
endmodule : cdsp_host_model

// ### tb.sv
// Purpose: Self-checking bench of the serial command port.
// Assumes: Results are checked when the update or reject pulse shows.
// Notes:   Expected results queue up in the order commands are sent.
`timescale 1ns/10ps

`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin \
error_cnt++; $display("ERROR t=%0t got %h exp %h", $time, g, e); end end

module tb;
   typedef struct {logic rej; logic [3:0] a; logic [15:0] v;} cdsp_note_t;
   logic clock_i = 1'b0, srst_i, host_shift_clock_i, serial_data_i;
   logic host_latch_strobe_i, chip_reset_low_i;
   logic [3:0]  auto_sequence_command_o, sequence_timer_setting_o;
   logic [8:0]  blind_time_us_o;
   logic [9:0]  brake_time_us_o;
   logic [3:0]  kick_time_setting_o, output_mode_select_o;
   logic [15:0] track_jump_count_o;
   logic [7:0]  function_select_o;
   logic [3:0]  audio_control_o, serial_bus_control_o;
   logic [3:0]  spindle_gain_setting_o, spindle_speed_control_o;
   logic [3:0]  spindle_speed_mode_o;
   logic        cmd_update_o, cmd_reject_o;
   int          error_cnt = 0, check_count = 0, cyc = 0;
   logic [31:0] seed;
   cdsp_note_t  exp_q[$];
   cdsp_note_t  n;

   always #20 clock_i = ~clock_i;

   cdsp_cmd_port dut_u (.clock_i(clock_i), .srst_i(srst_i),
      .host_shift_clock_i(host_shift_clock_i),
      .serial_data_i(serial_data_i),
      .host_latch_strobe_i(host_latch_strobe_i),
      .chip_reset_low_i(chip_reset_low_i),
      .auto_sequence_command_o(auto_sequence_command_o),
      .sequence_timer_setting_o(sequence_timer_setting_o),
      .blind_time_us_o(blind_time_us_o),
      .brake_time_us_o(brake_time_us_o),
      .kick_time_setting_o(kick_time_setting_o),
      .track_jump_count_o(track_jump_count_o),
      .output_mode_select_o(output_mode_select_o),
      .function_select_o(function_select_o),
      .audio_control_o(audio_control_o),
      .serial_bus_control_o(serial_bus_control_o),
      .spindle_gain_setting_o(spindle_gain_setting_o),
      .spindle_speed_control_o(spindle_speed_control_o),
      .spindle_speed_mode_o(spindle_speed_mode_o),
      .cmd_update_o(cmd_update_o), .cmd_reject_o(cmd_reject_o));
   cdsp_host_model host_u (.clock_i(clock_i),
      .host_shift_clock_o(host_shift_clock_i),
      .serial_data_o(serial_data_i),
      .host_latch_strobe_o(host_latch_strobe_i),
      .subcode_pw_read_clock_o(), .subcode_q_read_clock_o());

   // ****************************************************************
   // Helpers
   // ****************************************************************
   function automatic logic [15:0] get(input logic [3:0] a);
      case (a)
         4'h4: get = {12'h0, auto_sequence_command_o};
         4'h5: get = {12'h0, sequence_timer_setting_o};
         4'h6: get = {12'h0, kick_time_setting_o};
         4'h7: get = track_jump_count_o;
         4'h8: get = {12'h0, output_mode_select_o};
         4'h9: get = {8'h0, function_select_o};
         4'ha: get = {12'h0, audio_control_o};
         4'hb: get = {12'h0, serial_bus_control_o};
         4'hc: get = {12'h0, spindle_gain_setting_o};
         4'hd: get = {12'h0, spindle_speed_control_o};
         default: get = {12'h0, spindle_speed_mode_o};
      endcase
   endfunction : get

   function automatic logic [9:0] bw(input logic [3:0] d, input logic k);
      bw = 10'h0;
      if (d[3]) bw += k ? cdsp_pkg::BRAKE_W3 : cdsp_pkg::BLIND_W3;
      if (d[2]) bw += k ? cdsp_pkg::BRAKE_W2 : cdsp_pkg::BLIND_W2;
      if (d[1]) bw += k ? cdsp_pkg::BRAKE_W1 : cdsp_pkg::BLIND_W1;
      if (d[0]) bw += k ? cdsp_pkg::BRAKE_W0 : cdsp_pkg::BLIND_W0;
   endfunction : bw

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      rnd = seed;
   endfunction : rnd

   task automatic cmd(input logic [3:0] a, input logic [15:0] d,
                      input int len, input logic rej);
      exp_q.push_back('{rej, a, d});
      host_u.send(a, d, len);
   endtask : cmd

   task automatic check_init();
      `CHK(get(4'h4), {12'h0, cdsp_pkg::RST_AUTOSEQ})
      `CHK(get(4'h5), {12'h0, cdsp_pkg::RST_TIMER})
      `CHK(get(4'h7), cdsp_pkg::RST_JUMPCNT)
      `CHK(get(4'h9), {8'h0, cdsp_pkg::RST_FUNCSEL})
      `CHK(get(4'he), {12'h0, cdsp_pkg::RST_SPMODE})
      `CHK({1'b0, blind_time_us_o}, bw(cdsp_pkg::RST_TIMER, 1'b0))
      `CHK(brake_time_us_o, bw(cdsp_pkg::RST_TIMER, 1'b1))
   endtask : check_init

   task automatic stop_test();
      $display("checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : stop_test

   // ****************************************************************
   // Result monitor
   // ****************************************************************
   always @(posedge clock_i) begin
      cyc++;
      if (cyc == 5000) begin
         error_cnt++;
         stop_test();
      end else if (cmd_update_o === 1'b1 || cmd_reject_o === 1'b1) begin
         if (exp_q.size() == 0) begin
            `CHK(1'b1, 1'b0)
         end else begin
            n = exp_q.pop_front();
            `CHK(cmd_reject_o, n.rej)
            if (!n.rej) begin
               `CHK(get(n.a), n.v)
            end
            if (!n.rej && n.a == 4'h5) begin
               `CHK({1'b0, blind_time_us_o}, bw(n.v[3:0], 1'b0))
               `CHK(brake_time_us_o, bw(n.v[3:0], 1'b1))
            end
         end
      end
   end

   // ****************************************************************
   // Stimulus
   // ****************************************************************
   logic [15:0] d;
   initial begin
      seed = 32'd77;
      srst_i = 1'b1;
      chip_reset_low_i = 1'b1;
      // The link side only sees the reset while the shift clock runs.
      fork
         host_u.shift(20'h0, 6);
         repeat (10) @(negedge clock_i);
      join
      srst_i = 1'b0;
      repeat (4) @(negedge clock_i);
      check_init();
      // The link still sits in reset for two shift edges, so a throwaway
      // command lines the bit count up and must come back rejected.
      cmd(4'h0, 16'h0000, 8, 1'b1);
      for (int a = 4; a <= 14; a++) begin
         repeat (2) begin
            d = rnd();
            if (a == 9) d &= 16'h0040;
            if (a == 10) d &= 16'h0003;
            if (a == 11) d &= 16'h000e;
            if (a != 7 && a != 9) d &= 16'h000f;
            if (a == 9) d &= 16'h00ff;
            cmd(a[3:0], d, (a == 7) ? 20 : (a == 9) ? 12 : 8, 1'b0);
         end
      end
      cmd(4'h7, 16'hffff, 20, 1'b0);
      cmd(4'h7, 16'h8000, 20, 1'b0);
      cmd(4'h5, 16'h000f, 8, 1'b0);
      cmd(4'h5, 16'h0008, 8, 1'b0);
      cmd(4'hf, 16'h0000, 8, 1'b1);
      cmd(4'h4, 16'h0007, 12, 1'b1);
      cmd(4'h0, 16'h0000, 8, 1'b1);
      chip_reset_low_i = 1'b0;
      repeat (6) @(negedge clock_i);
      check_init();
      chip_reset_low_i = 1'b1;
      repeat (4) @(negedge clock_i);
      cmd(4'h5, 16'h0000, 8, 1'b0);
      repeat (8) @(negedge clock_i);
      `CHK(exp_q.size(), 0)
      stop_test();
   end
endmodule : tb
